// File: hw/measured_value_limit_reporter.sv
// Decided for this implementation: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "mvlr_defines.svh"
module measured_value_limit_reporter #(
  parameter int unsigned TICK_CYCLES = `UNIT_S * `CLK_HZ,
  parameter int unsigned SEND_DLY_CYCLES = `SEND_DLY_S * `CLK_HZ
) (
  input  wire logic                        hclk,       // bus clock
  input  wire logic                        hresetn,    // async reset, low
  input  wire logic                        hsel,       // slave select
  input  wire logic [31:0]                 haddr,      // byte address
  input  wire logic [1:0]                  htrans,     // transfer type
  input  wire logic                        hwrite,     // write phase
  input  wire logic [2:0]                  hsize,      // word only
  input  wire logic [31:0]                 hwdata,     // write data
  input  wire logic                        hready,     // bus ready
  output var  logic [31:0]                 hrdata,     // read data
  output var  logic                        hreadyout,  // slave ready
  output var  logic                        hresp,      // always okay
  input  wire mvlr_pkg::smp_t              smp,        // raw sample
  input  wire logic                        reinit_req, // bus return or download
  output var  mvlr_pkg::mv_tlg_t           mv_tlg,     // value telegram
  output wire mvlr_pkg::lim_tlg_t [1:0]    lim_tlg     // limit telegrams
);
  logic [8:0]         ctrl_r;
  logic signed [23:0] rlo_r;
  logic signed [23:0] rhi_r;
  logic [23:0]        cyc_r;
  logic signed [23:0] lthr_r [2];
  logic signed [23:0] lhys_r [2];
  logic [15:0]        lmode_r;
  logic [31:0]        ldly_r;
  logic               ph_wr_r;
  logic [7:0]         ph_addr_r;
  logic               reinit_r;
  logic signed [23:0] cond_val;
  logic signed [23:0] cur_r;
  logic               vld_r;
  logic               seen_r;
  logic [31:0]        tick_cnt_r;
  logic               tick;
  logic [2:0]         fire;
  logic [1:0]         del_v;
  logic [1:0]         lock_v;
  logic signed [23:0] thr_v [2];
  logic               addr_ok;
  logic               wr_ok;
  mvlr_pkg::mv_st_t   mv_st_r;
  // ahb-lite slave, zero wait states
  assign addr_ok = hsel & hready & htrans[1];
  assign wr_ok   = ph_wr_r;
  function automatic logic we(input logic [7:0] a);
    we = wr_ok && (ph_addr_r == a);
  endfunction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr_r   <= 1'b0;
      ph_addr_r <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      ph_wr_r   <= addr_ok & hwrite;
      ph_addr_r <= haddr[7:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
  // reads are decoded in the address phase so data is a flop in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_ok && !hwrite) begin
      case (haddr[7:0])
        `A_CTRL:  hrdata <= {23'h000000, ctrl_r};
        `A_RLO:   hrdata <= {{8{rlo_r[23]}}, rlo_r};
        `A_RHI:   hrdata <= {{8{rhi_r[23]}}, rhi_r};
        `A_CYC:   hrdata <= {8'h00, cyc_r};
        `A_L1THR: hrdata <= {{8{lthr_r[0][23]}}, lthr_r[0]};
        `A_L1HYS: hrdata <= {8'h00, lhys_r[0]};
        `A_L2THR: hrdata <= {{8{lthr_r[1][23]}}, lthr_r[1]};
        `A_L2HYS: hrdata <= {8'h00, lhys_r[1]};
        `A_LMODE: hrdata <= {16'h0000, lmode_r};
        `A_LDLY:  hrdata <= ldly_r;
        `A_STAT:  hrdata <= {3'h0, mv_st_r == mvlr_pkg::MV_HOLD, lock_v, del_v, cur_r};
        `A_THR1:  hrdata <= {{8{thr_v[0][23]}}, thr_v[0]};
        `A_THR2:  hrdata <= {{8{thr_v[1][23]}}, thr_v[1]};
        default:  hrdata <= 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r    <= `CTRL_RST;
      rlo_r     <= `VAL_RST;
      rhi_r     <= `VAL_RST;
      cyc_r     <= `CYC_RST;
      lthr_r[0] <= `VAL_RST;
      lthr_r[1] <= `VAL_RST;
      lhys_r[0] <= `VAL_RST;
      lhys_r[1] <= `VAL_RST;
      lmode_r   <= `LMODE_RST;
      ldly_r    <= `LDLY_RST;
    end else begin
      if (we(`A_CTRL)) ctrl_r <= hwdata[8:0] & 9'h1BF;
      if (we(`A_RLO)) rlo_r <= hwdata[23:0];
      if (we(`A_RHI)) rhi_r <= hwdata[23:0];
      if (we(`A_CYC)) cyc_r <= hwdata[23:0];
      if (we(`A_L1THR)) lthr_r[0] <= hwdata[23:0];
      if (we(`A_L1HYS)) lhys_r[0] <= hwdata[23:0];
      if (we(`A_L2THR)) lthr_r[1] <= hwdata[23:0];
      if (we(`A_L2HYS)) lhys_r[1] <= hwdata[23:0];
      if (we(`A_LMODE)) lmode_r <= hwdata[15:0] & 16'h1F1F;
      if (we(`A_LDLY)) ldly_r <= hwdata;
    end
  end
  // re-initialisation: bus voltage return, download, or software strobe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) reinit_r <= 1'b1;
    else reinit_r <= reinit_req | (we(`A_CTRL) & hwdata[`C_REINIT]);
  end
  // sample conditioning
  always_comb begin
    case (mvlr_pkg::cond_t'(ctrl_r[`C_COND]))
      mvlr_pkg::COND_BRIGHT: cond_val = (smp.value < `BRIGHT_FLOOR) ? 24'sh000000 : smp.value;
      mvlr_pkg::COND_TWI:    cond_val = (smp.value > `TWI_CEIL) ? `TWI_CEIL : smp.value;
      default:               cond_val = smp.value;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_r  <= `VAL_RST;
      vld_r  <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      vld_r <= smp.valid;
      if (smp.valid) begin
        cur_r <= ctrl_r[`C_BIN] ? {23'h000000, smp.value[0]} : cond_val;
        seen_r <= 1'b1;
      end
    end
  end
  // ten second time base shared by the cyclic counters and the on and off delay counters
  assign tick = (tick_cnt_r == TICK_CYCLES - 1);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tick_cnt_r <= 32'h00000000;
    else tick_cnt_r <= tick ? 32'h00000000 : tick_cnt_r + 32'h00000001;
  end
  // one cycle counter each: 0 measured value, 1 and 2 the limits
  for (genvar i = 0; i < 3; i++) begin : g_cyc
    logic [7:0] cnt_r;
    logic [7:0] set;
    assign set = (cyc_r[8*i +: 8] > `CYC_MAX) ? `CYC_MAX : cyc_r[8*i +: 8];
    assign fire[i] = tick && (set != 8'h00) && (cnt_r + 8'h01 >= set);
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) cnt_r <= 8'h00;
      else if (reinit_r || set == 8'h00) cnt_r <= 8'h00;
      else if (fire[i]) cnt_r <= 8'h00;
      else if (tick) cnt_r <= cnt_r + 8'h01;
    end
  end
  // measured value path
  logic [31:0]        sd_cnt_r;
  logic signed [23:0] last_r;
  logic               have_r;
  logic [31:0]        span;
  logic [31:0]        kf;
  logic [31:0]        step;
  logic signed [24:0] diff;
  logic [24:0]        adiff;
  logic               chg_hit;
  logic               cyc_send;
  logic               hold_done;
  assign span = ctrl_r[`C_TEMP] ? {8'h00, `TEMP_SPAN} : {8'h00, rhi_r};
  always_comb begin
    case (ctrl_r[`C_STEP])
      2'b00:   kf = `PCT_K0;
      2'b01:   kf = `PCT_K1;
      2'b10:   kf = `PCT_K2;
      default: kf = `PCT_K3;
    endcase
  end
  assign step = (span * kf) / `PCT_DEN;
  assign diff = $signed({cur_r[23], cur_r}) - $signed({last_r[23], last_r});
  assign adiff = diff[24] ? 25'(-diff) : 25'(diff);
  // comfort and binary channels never send the measured value on change
  assign chg_hit = vld_r && ctrl_r[`C_CHG] && !ctrl_r[`C_COMF] && !ctrl_r[`C_BIN] &&
                   (!have_r || {7'h00, adiff} >= step);
  assign cyc_send = fire[0] && seen_r && !ctrl_r[`C_BIN];
  assign hold_done = (mv_st_r == mvlr_pkg::MV_HOLD) && (sd_cnt_r == 32'h00000000);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mv_st_r  <= mvlr_pkg::MV_IDLE;
      sd_cnt_r <= 32'h00000000;
    end else if (reinit_r) begin
      mv_st_r  <= mvlr_pkg::MV_IDLE;
      sd_cnt_r <= 32'h00000000;
    end else begin
      case (mv_st_r)
        mvlr_pkg::MV_IDLE: begin
          if (chg_hit) begin
            mv_st_r  <= mvlr_pkg::MV_HOLD;
            sd_cnt_r <= SEND_DLY_CYCLES - 1;
          end
        end
        mvlr_pkg::MV_HOLD: begin
          if (hold_done) mv_st_r <= mvlr_pkg::MV_IDLE;
          else sd_cnt_r <= sd_cnt_r - 32'h00000001;
        end
        default: mv_st_r <= mvlr_pkg::MV_IDLE;
      endcase
    end
  end
  // the latest value goes out when the delay ends, not the one that triggered it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mv_tlg <= '0;
      last_r <= `VAL_RST;
      have_r <= 1'b0;
    end else begin
      mv_tlg.send <= hold_done | cyc_send;
      if (hold_done | cyc_send) begin
        mv_tlg.value <= cur_r;
        last_r <= cur_r;
        have_r <= 1'b1;
      end
      if (reinit_r) have_r <= 1'b0;
    end
  end
  // limit comparators
  for (genvar l = 0; l < 2; l++) begin : g_lim
    logic signed [23:0] thr_r;
    logic               int_r;
    logic               del_r;
    logic               done_r;
    logic [7:0]         dc_r;
    mvlr_pkg::lim_tlg_t lt_r;
    logic [4:0]         m;
    logic               under;
    logic               a_snd;
    logic               a_val;
    logic               i_snd;
    logic               i_val;
    logic signed [24:0] thr_x;
    logic signed [24:0] hys_x;
    logic               enter;
    logic               leave;
    logic               stuck;
    logic [7:0]         need;
    logic               del_go;
    logic               ch_snd;
    logic               cy_snd;
    assign m = lmode_r[8*l +: 5];
    // mode index -> direction and the value each transition sends
    always_comb begin
      under = 1'b0;
      a_snd = 1'b1;
      a_val = 1'b1;
      i_snd = 1'b1;
      i_val = 1'b0;
      case (m[3:0])
        4'h0: begin under = 1'b0; a_val = 1'b1; i_val = 1'b0; end
        4'h1: begin under = 1'b0; a_val = 1'b0; i_val = 1'b1; end
        4'h2: begin under = 1'b1; a_val = 1'b1; i_val = 1'b0; end
        4'h3: begin under = 1'b1; a_val = 1'b0; i_val = 1'b1; end
        4'h4: begin under = 1'b0; a_val = 1'b1; i_snd = 1'b0; end
        4'h5: begin under = 1'b0; a_val = 1'b0; i_snd = 1'b0; end
        4'h6: begin under = 1'b1; a_val = 1'b1; i_snd = 1'b0; end
        4'h7: begin under = 1'b1; a_val = 1'b0; i_snd = 1'b0; end
        4'h8: begin under = 1'b0; a_snd = 1'b0; i_val = 1'b0; end
        4'h9: begin under = 1'b0; a_snd = 1'b0; i_val = 1'b1; end
        4'hA: begin under = 1'b1; a_snd = 1'b0; i_val = 1'b0; end
        4'hB: begin under = 1'b1; a_snd = 1'b0; i_val = 1'b1; end
        default: begin under = 1'b0; a_val = 1'b1; i_val = 1'b0; end
      endcase
    end
    assign thr_x = $signed({thr_r[23], thr_r});
    assign hys_x = $signed({lhys_r[l][23], lhys_r[l]});
    assign enter = under ? ($signed({cur_r[23], cur_r}) < thr_x) : ($signed({cur_r[23], cur_r}) > thr_x);
    assign leave = under ? ($signed({cur_r[23], cur_r}) > thr_x + hys_x)
                         : ($signed({cur_r[23], cur_r}) < thr_x - hys_x);
    // a return edge at or past the range end can never be crossed again
    assign stuck = under ? (thr_x + hys_x >= $signed({rhi_r[23], rhi_r}))
                         : (thr_x - hys_x <= $signed({rlo_r[23], rlo_r}));
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) thr_r <= `VAL_RST;
      else if (reinit_r) thr_r <= lthr_r[l];
      else if (we(l == 0 ? `A_EXT1 : `A_EXT2)) thr_r <= hwdata[23:0];
      else if (we(`A_TEACH) && hwdata[l]) thr_r <= cur_r;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        int_r  <= 1'b0;
        done_r <= 1'b0;
      end else if (reinit_r) begin
        int_r  <= 1'b0;
        done_r <= 1'b0;
      end else if (vld_r && !ctrl_r[`C_COMF] && !(stuck && done_r)) begin
        if (!int_r && enter) begin
          int_r  <= 1'b1;
          done_r <= 1'b1;
        end else if (int_r && leave) begin
          int_r  <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
    // on and off delays counted in ten second units
    assign need = int_r ? ldly_r[16*l +: 8] : ldly_r[16*l+8 +: 8];
    assign del_go = (int_r != del_r) && (need == 8'h00 || (tick && dc_r + 8'h01 >= need));
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        del_r <= 1'b0;
        dc_r  <= 8'h00;
      end else if (reinit_r) begin
        del_r <= 1'b0;
        dc_r  <= 8'h00;
      end else if (del_go) begin
        del_r <= int_r;
        dc_r  <= 8'h00;
      end else if (int_r == del_r) begin
        dc_r <= 8'h00;
      end else if (tick) begin
        dc_r <= dc_r + 8'h01;
      end
    end
    assign ch_snd = m[4] && (int_r ? a_snd : i_snd);
    assign cy_snd = fire[l+1] && (del_r ? a_snd : i_snd);
    // only fire[l+1] drives the cycle here, so value sends cannot shift it
    // level moves only with a telegram, so receivers never see an unsent state
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        lt_r <= '0;
      end else if (del_go) begin
        lt_r.send <= ch_snd;
        if (ch_snd) lt_r.level <= int_r ? a_val : i_val;
      end else begin
        lt_r.send <= cy_snd;
        if (cy_snd) lt_r.level <= del_r ? a_val : i_val;
      end
    end
    assign lim_tlg[l] = lt_r;
    assign del_v[l]   = del_r;
    assign lock_v[l]  = stuck & done_r;
    assign thr_v[l]   = thr_r;
  end
endmodule
`default_nettype wire

// File: hw/mvlr_defines.svh
`ifndef MVLR_DEFINES_SVH
`define MVLR_DEFINES_SVH
// clock and time base
`define CLK_HZ        40000000
`define UNIT_S        10
`define SEND_DLY_S    10
`define CYC_MAX       8'h78
// value conditioning and change steps
`define BRIGHT_FLOOR  24'sh0003E8
`define TWI_CEIL      24'sh000384
`define TEMP_SPAN     24'h000384
`define PCT_DEN       32'h000000C8
`define PCT_K0        32'h00000001
`define PCT_K1        32'h00000002
`define PCT_K2        32'h00000006
`define PCT_K3        32'h00000014
// register byte offsets
`define A_CTRL        8'h00
`define A_RLO         8'h04
`define A_RHI         8'h08
`define A_CYC         8'h0C
`define A_L1THR       8'h10
`define A_L1HYS       8'h14
`define A_L2THR       8'h18
`define A_L2HYS       8'h1C
`define A_LMODE       8'h20
`define A_LDLY        8'h24
`define A_EXT1        8'h28
`define A_EXT2        8'h2C
`define A_TEACH       8'h30
`define A_STAT        8'h34
`define A_THR1        8'h38
`define A_THR2        8'h3C
// control fields
`define C_STEP        1:0
`define C_COND        3:2
`define C_TEMP        4
`define C_CHG         5
`define C_REINIT      6
`define C_BIN         7
`define C_COMF        8
// reset values
`define CTRL_RST      9'h000
`define VAL_RST       24'h000000
`define CYC_RST       24'h000000
`define LMODE_RST     16'h0000
`define LDLY_RST      32'h00000000
`endif

// File: hw/mvlr_pkg.sv
package mvlr_pkg;
  typedef struct packed {
    logic               valid;
    logic signed [23:0] value;
  } smp_t;
  typedef struct packed {
    logic               send;
    logic signed [23:0] value;
  } mv_tlg_t;
  typedef struct packed {
    logic send;
    logic level;
  } lim_tlg_t;
  typedef enum logic [1:0] {
    COND_NONE   = 2'b00,
    COND_BRIGHT = 2'b01,
    COND_TWI    = 2'b10
  } cond_t;
  typedef enum logic {
    MV_IDLE = 1'b0,
    MV_HOLD = 1'b1
  } mv_st_t;
endpackage

// File: sim/measured_value_limit_reporter_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "mvlr_defines.svh"
module measured_value_limit_reporter_tb;
  localparam int unsigned TICK = 20;
  localparam int unsigned SDLY = 10;
  logic                     hclk, hresetn, hsel, hwrite, reinit_req, hready, hresp;
  logic [31:0]              haddr, hwdata, hrdata;
  logic [1:0]               htrans;
  logic [2:0]               hsize;
  mvlr_pkg::smp_t           smp;
  mvlr_pkg::mv_tlg_t        mv_tlg;
  wire mvlr_pkg::lim_tlg_t [1:0] lim_tlg;
  logic [15:0]              mv_cnt;
  logic signed [23:0]       mv_val;
  logic [1:0][15:0]         lim_cnt;
  logic [1:0]               lim_lvl;
  int                       err_count, total_checks, cyc_n;
  measured_value_limit_reporter #(.TICK_CYCLES(TICK), .SEND_DLY_CYCLES(SDLY)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .smp(smp), .reinit_req(reinit_req),
    .mv_tlg(mv_tlg), .lim_tlg(lim_tlg));
  mvlr_partner far_end (.hclk(hclk), .hresetn(hresetn), .mv_tlg(mv_tlg), .lim_tlg(lim_tlg),
    .mv_cnt(mv_cnt), .mv_val(mv_val), .lim_cnt(lim_cnt), .lim_lvl(lim_lvl));
  always #12.5 hclk = ~hclk;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(what, q, exp);
  endtask
  // control write with the reinit strobe set, so every setup starts clean
  task automatic cfg(input logic [31:0] c);
    wr(`A_CTRL, c | 32'h40);
    @(posedge hclk);
  endtask
  task automatic put(input logic signed [23:0] v);
    smp <= '{valid: 1'b1, value: v};
    @(posedge hclk);
    smp.valid <= 1'b0;
    @(posedge hclk);
  endtask
  task automatic wait_mv(input int lim, output logic got, output int n);
    logic [15:0] c0;
    c0 = mv_cnt;
    n = 0;
    while (n < lim && mv_cnt === c0) begin
      @(posedge hclk);
      n++;
    end
    got = (mv_cnt !== c0);
  endtask
  task automatic t_thr;
    wr(`A_RHI, 32'h3E8);
    wr(`A_L1THR, 32'h1F4);
    cfg(32'h0);
    rdc("thr1 configured", `A_THR1, 32'h1F4);
    wr(`A_EXT1, 32'h2BC);
    rdc("thr1 external", `A_THR1, 32'h2BC);
    put(24'sh12C);
    wr(`A_TEACH, 32'h0);
    rdc("thr1 teach zero", `A_THR1, 32'h2BC);
    wr(`A_TEACH, 32'h1);
    rdc("thr1 taught", `A_THR1, 32'h12C);
    rdc("external reads zero", `A_EXT1, 32'h0);
    rdc("unmapped", 8'h80, 32'h0);
    check("response okay", hresp, 32'h0);
    reinit_req <= 1'b1;
    @(posedge hclk);
    reinit_req <= 1'b0;
    @(posedge hclk);
    rdc("thr1 after reinit", `A_THR1, 32'h1F4);
    $display("test thresholds done");
  endtask
  task automatic t_lim;
    logic signed [23:0] v [5] = '{24'sh96, 24'sh5A, 24'sh46, 24'shFA, 24'sh96};
    logic [4:0]         e1 = 5'h1B;
    logic [4:0]         e2 = 5'h08;
    logic [1:0][15:0]   c0;
    wr(`A_L1THR, 32'h64);
    wr(`A_L1HYS, 32'h14);
    wr(`A_L2THR, 32'hC8);
    wr(`A_L2HYS, 32'h0);
    wr(`A_LMODE, 32'h1010);
    cfg(32'h0);
    c0 = lim_cnt;
    for (int i = 0; i < 5; i++) begin
      put(v[i]);
      repeat (6) @(posedge hclk);
      check("limit 1 level", lim_lvl[0], e1[i]);
      check("limit 2 level", lim_lvl[1], e2[i]);
    end
    check("limit 1 sends", lim_cnt[0] - c0[0], 32'h3);
    check("limit 2 sends", lim_cnt[1] - c0[1], 32'h2);
    wr(`A_L1HYS, 32'hC8);
    cfg(32'h0);
    c0 = lim_cnt;
    put(24'sh96);
    put(-24'sh96);
    repeat (6) @(posedge hclk);
    check("locked limit sends", lim_cnt[0] - c0[0], 32'h1);
    check("locked limit level", lim_lvl[0], 32'h1);
    $display("test limits done");
  endtask
  task automatic t_step;
    logic [23:0] st [5] = '{24'h5, 24'hA, 24'h1E, 24'h64, 24'h5A};
    logic        got;
    int          n;
    for (int k = 0; k < 5; k++) begin
      cfg(k == 4 ? 32'h33 : 32'h20 | 32'(k));
      put(24'sh1F4);
      wait_mv(60, got, n);
      check("first send", mv_val, 32'h1F4);
      check("send delay", n >= SDLY - 2, 32'h1);
      put(24'sh1F4 + st[k] - 24'h1);
      wait_mv(SDLY + 12, got, n);
      check("below step", got, 32'h0);
      put(24'sh1F4 + st[k]);
      wait_mv(60, got, n);
      check("at step", mv_val, 32'h1F4 + 32'(st[k]));
    end
    $display("test change steps done");
  endtask
  task automatic t_cond;
    logic got;
    int   n;
    cfg(32'h25);
    put(24'sh3E8);
    wait_mv(60, got, n);
    check("brightness", mv_val, 32'h3E8);
    put(24'sh3E7);
    wait_mv(60, got, n);
    check("dim brightness", mv_val, 32'h0);
    cfg(32'h29);
    put(24'sh320);
    wait_mv(60, got, n);
    put(24'sh5DC);
    wait_mv(60, got, n);
    check("twilight", mv_val, 32'h384);
    cfg(32'hA0);
    put(24'sh1);
    wait_mv(SDLY + 12, got, n);
    check("binary sends", got, 32'h0);
    cfg(32'h120);
    put(24'sh1F4);
    wait_mv(SDLY + 12, got, n);
    check("comfort change", got, 32'h0);
    wr(`A_CYC, 32'h2);
    wait_mv(200, got, n);
    wait_mv(200, got, n);
    check("cyclic period", n, 2 * TICK);
    check("comfort cyclic", mv_val, 32'h1F4);
    wr(`A_CYC, 32'h0);
    wait_mv(6 * TICK, got, n);
    check("cyclic off", got, 32'h0);
    $display("test conditioning and cycles done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // the whole run needs under a thousand cycles
  always @(posedge hclk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      err_count++;
      close_out;
    end
  end
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    {hsel, hwrite, reinit_req, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    smp = '0;
    {err_count, total_checks, cyc_n} = '0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_thr;
    t_lim;
    t_step;
    t_cond;
    close_out;
  end
endmodule
`default_nettype wire

// File: sim/mvlr_partner.sv
`timescale 1ns/1ps
`default_nettype none
module mvlr_partner (
  input  wire logic                     hclk,    // clock
  input  wire logic                     hresetn, // reset, low
  input  wire mvlr_pkg::mv_tlg_t        mv_tlg,  // value telegrams
  input  wire mvlr_pkg::lim_tlg_t [1:0] lim_tlg, // limit telegrams
  output var  logic [15:0]              mv_cnt,  // values received
  output var  logic signed [23:0]       mv_val,  // last value received
  output var  logic [1:0][15:0]         lim_cnt, // limit telegrams received
  output var  logic [1:0]               lim_lvl  // last limit levels
);
  // a receiver takes a telegram only on its send pulse, never the idle value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mv_cnt  <= 16'h0;
      mv_val  <= 24'sh0;
      lim_cnt <= '0;
      lim_lvl <= 2'h0;
    end else begin
      if (mv_tlg.send) begin
        mv_cnt <= mv_cnt + 16'h1;
        mv_val <= mv_tlg.value;
      end
      for (int i = 0; i < 2; i++) begin
        if (lim_tlg[i].send) begin
          lim_cnt[i] <= lim_cnt[i] + 16'h1;
          lim_lvl[i] <= lim_tlg[i].level;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: sim/mvlr_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "mvlr_defines.svh"
module mvlr_props #(
  parameter int unsigned TICK_CYCLES     = 20,
  parameter int unsigned SEND_DLY_CYCLES = 10
) (
  input  wire logic                     hclk,       // clock
  input  wire logic                     hresetn,    // reset, low
  input  wire logic                     hsel,       // select
  input  wire logic [31:0]              haddr,      // address
  input  wire logic [1:0]               htrans,     // transfer type
  input  wire logic                     hwrite,     // write
  input  wire logic [31:0]              hwdata,     // write data
  input  wire logic                     hready,     // bus ready
  input  wire logic                     reinit_req, // reinit pulse
  input  wire mvlr_pkg::mv_tlg_t        mv_tlg,     // value telegram
  input  wire mvlr_pkg::lim_tlg_t [1:0] lim_tlg     // limit telegrams
);
  logic        wr_r;
  logic [7:0]  adr_r;
  logic [8:0]  ctrl_r;
  logic [7:0]  cyc_r;
  logic [31:0] gap_r;
  logic [31:0] age_r;
  logic        gok_r;
  logic        cfg_wr;
  logic [31:0] per;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  assign cfg_wr = wr_r && (adr_r == `A_CTRL || adr_r == `A_CYC);
  // settings above the ceiling run at the ceiling
  assign per = ((cyc_r > `CYC_MAX) ? 32'h78 : {24'h0, cyc_r}) * TICK_CYCLES;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r  <= 1'b0;
      adr_r <= 8'h0;
    end else if (hready) begin
      wr_r  <= hsel && htrans[1] && hwrite;
      adr_r <= haddr[7:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= 9'h0;
      cyc_r  <= 8'h0;
    end else if (wr_r && adr_r == `A_CTRL) begin
      ctrl_r <= hwdata[8:0];
    end else if (wr_r && adr_r == `A_CYC) begin
      cyc_r <= hwdata[7:0];
    end
  end
  // gaps only count when both sends ran under the same settings
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_r <= 32'h0;
      gok_r <= 1'b0;
      age_r <= 32'h0;
    end else begin
      gap_r <= mv_tlg.send ? 32'h1 : gap_r + 32'h1;
      gok_r <= (gok_r || mv_tlg.send) && !cfg_wr && !reinit_req;
      age_r <= (cfg_wr || reinit_req) ? 32'h0 : age_r + {31'h0, ~age_r[31]};
    end
  end
  sequence s_send;
    mv_tlg.send;
  endsequence
  sequence s_quiet;
    age_r > SEND_DLY_CYCLES + 8;
  endsequence
  property p_bright;
    s_quiet ##0 s_send ##0 ctrl_r[3:2] == 2'b01 |-> mv_tlg.value == 24'sh0 || mv_tlg.value >= 24'sh3E8;
  endproperty
  property p_twi;
    s_quiet ##0 s_send ##0 ctrl_r[3:2] == 2'b10 |-> mv_tlg.value <= 24'sh384;
  endproperty
  property p_bin;
    s_quiet ##0 ctrl_r[7] |-> !mv_tlg.send;
  endproperty
  property p_off;
    s_quiet ##0 (!ctrl_r[5] && cyc_r == 8'h0) |-> !mv_tlg.send;
  endproperty
  property p_cyc;
    s_send ##0 (gok_r && (!ctrl_r[5] || ctrl_r[8]) && cyc_r != 8'h0) |-> gap_r == per;
  endproperty
  property p_dly;
    s_send ##0 (gok_r && ctrl_r[5] && cyc_r == 8'h0) |-> gap_r > SEND_DLY_CYCLES;
  endproperty
  property p_lvl0;
    !lim_tlg[0].send |-> $stable(lim_tlg[0].level);
  endproperty
  property p_lvl1;
    lim_tlg[1].level != $past(lim_tlg[1].level) |-> lim_tlg[1].send;
  endproperty
  a_bright: assert property (p_bright) else $error("brightness value under floor sent");
  a_twi: assert property (p_twi) else $error("twilight value above ceiling sent");
  a_bin: assert property (p_bin) else $error("binary channel sent a value");
  a_off: assert property (p_off) else $error("value sent with cyclic and change off");
  a_cyc: assert property (p_cyc) else $error("cyclic period wrong");
  a_dly: assert property (p_dly) else $error("change sends closer than send delay");
  a_lvl0: assert property (p_lvl0) else $error("limit 1 level moved without telegram");
  a_lvl1: assert property (p_lvl1) else $error("limit 2 level moved without telegram");
endmodule
bind measured_value_limit_reporter mvlr_props #(
  .TICK_CYCLES(TICK_CYCLES),
  .SEND_DLY_CYCLES(SEND_DLY_CYCLES)
) u_props (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hready(hready),
  .reinit_req(reinit_req),
  .mv_tlg(mv_tlg),
  .lim_tlg(lim_tlg)
);
`default_nettype wire
